// *** core/bmmd_pkg.sv ***
// Package of constants and types for the boot mode memory decoder
package bmmd_pkg;

  localparam int          ADDR_W        = 23;
  localparam logic [22:0] ROM_LO        = 23'h000000;
  localparam logic [22:0] ROM_HI        = 23'h00bfff;
  localparam logic [22:0] FIXED_LO      = 23'h00c000;
  localparam logic [22:0] FIXED_HI      = 23'h00ffff;
  localparam logic [22:0] IO_LO         = 23'h00ff00;
  localparam logic [22:0] FONT_LO       = 23'h010000;
  localparam logic [22:0] FONT_HI       = 23'h08ffff;
  localparam logic [22:0] EXPAN_LO      = 23'h100000;
  localparam logic [22:0] EXPAN_HI      = 23'h4fffff;
  localparam logic [22:0] MPU_HI        = 23'h3fffff;
  localparam logic [22:0] SPACE_HI      = 23'h3fffff;
  localparam logic [1:0]  BANK_COUNT    = 2'h3;
  localparam logic        STRAP_INT     = 1'b1;
  localparam logic        CUSTOM_FLAG   = 1'b0;
  localparam logic [3:0]  CE_IDLE       = 4'hf;
  localparam logic [7:0]  PORT_RESET    = 8'h00;
  localparam logic [1:0]  SYNC_FILL     = 2'h3;

  typedef enum logic [1:0] {
    BMMD_IDLE  = 2'b00,
    BMMD_SETUP = 2'b01,
    BMMD_STROBE = 2'b11
  } bmmd_state_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [22:0] addr;
    logic [7:0]  wdata;
  } bmmd_access_type;

  typedef struct packed {
    logic [3:0] ceN;
    logic       rdN;
    logic       wrN;
    logic [7:0] dataOut;
    logic       dataOe;
  } bmmd_ext_type;

endpackage

// *** core/bmmd_strap_sync.sv ***
// Three-stage synchroniser for the boot mode strap pin
`timescale 1ns/100ps
module bmmd_strap_sync (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      stable
);
  logic meta_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      s2_q   <= 1'b1;
      s3_q   <= 1'b1;
    end else begin
      meta_q <= pinIn;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  assign level  = s3_q;
  assign stable = (s2_q == s3_q);
endmodule

// *** core/bmmd_decoder.sv ***
// Boot mode latch and memory access steering
`timescale 1ns/100ps
module bmmd_decoder (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      boot_mode_strap,
  input  wire bmmd_pkg::bmmd_access_type cpuAccess,
  input  wire logic                      busConfigured,
  input  wire logic                      singleChipReq,
  input  wire logic [7:0]                portOut,
  input  wire logic [7:0]                portOe,
  input  wire logic [7:0]                ext_data_bus_in,
  output bmmd_pkg::bmmd_ext_type         extBus,
  output logic [7:0]                     portPinOut,
  output logic [7:0]                     portPinOe,
  output logic                           external_rom_mode,
  output logic                           singleChip,
  output logic                           intSelect,
  output logic                           accessDone,
  output logic [7:0]                     extRdata,
  output logic                           custom_condition_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic       strapLevel;
  logic       strapStable;
  logic [1:0] fill_q;
  logic       latched_q;
  logic       modeInt_q;
  logic       extMode_q;

  bmmd_strap_sync uSync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pinIn   (boot_mode_strap),
    .level   (strapLevel),
    .stable  (strapStable)
  );

  // Edges needed to flush the synchroniser reset value
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_q <= 2'h0;
    end else if (fill_q != bmmd_pkg::SYNC_FILL) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // Captured once the pin fills all stages, then frozen
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0;
      modeInt_q <= bmmd_pkg::STRAP_INT;
      extMode_q <= 1'b0;
    end else if (!latched_q && fill_q == bmmd_pkg::SYNC_FILL && strapStable) begin
      latched_q <= 1'b1;
      modeInt_q <= (strapLevel == bmmd_pkg::STRAP_INT);
      extMode_q <= (strapLevel != bmmd_pkg::STRAP_INT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [22:0] a;
  logic        inSpace;
  logic        hitRom;
  logic        hitFixed;
  logic        hitIo;
  logic        hitFont;
  logic        hitExpan;
  logic        goExt;
  logic        goInt;
  logic        singleChip_q;

  assign a        = cpuAccess.addr;
  assign inSpace  = (a <= bmmd_pkg::EXPAN_HI);
  assign hitRom   = (a <= bmmd_pkg::ROM_HI);
  assign hitFixed = (a >= bmmd_pkg::FIXED_LO) && (a <= bmmd_pkg::FIXED_HI);
  assign hitIo    = (a >= bmmd_pkg::IO_LO) && (a <= bmmd_pkg::FIXED_HI);
  assign hitFont  = (a >= bmmd_pkg::FONT_LO) && (a <= bmmd_pkg::FONT_HI);
  assign hitExpan = (a >= bmmd_pkg::EXPAN_LO) && (a <= bmmd_pkg::EXPAN_HI);

  // Fixed block first, then mode, then expansion window
  always_comb begin
    goExt = 1'b0;
    if (hitFixed || hitIo) begin
      goExt = 1'b0;
    end else if (!modeInt_q) begin
      goExt = (a <= bmmd_pkg::MPU_HI);
    end else if (hitExpan) begin
      goExt = 1'b1;
    end
    goExt = goExt && inSpace && busConfigured && !singleChip_q;
  end

  assign goInt = inSpace && !goExt && (hitFixed || (modeInt_q && (hitRom || hitFont)));

  ////////////////////////////////////////////////////////////////////////////
  // External strobe sequencer
  bmmd_pkg::bmmd_state_type state_q;
  bmmd_pkg::bmmd_ext_type   ext_q;
  logic                     intSel_q;
  logic                     done_q;
  logic [7:0]               rdata_q;
  logic [1:0]               bank;
  logic [3:0]               ceSel;

  assign bank = a[21:20];

  // One active-low select per megabyte bank
  for (genvar g = 0; g < 4; g++) begin : gBank
    assign ceSel[g] = (bank != 2'(g));
  end

  // Chip enable, then strobe, then release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bmmd_pkg::BMMD_IDLE;
      ext_q   <= '{ceN: bmmd_pkg::CE_IDLE, rdN: 1'b1, wrN: 1'b1, dataOut: 8'h00, dataOe: 1'b0};
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        bmmd_pkg::BMMD_IDLE: begin
          if (cpuAccess.req && goExt && latched_q) begin
            state_q     <= bmmd_pkg::BMMD_SETUP;
            ext_q.ceN   <= ceSel;
            ext_q.dataOut <= cpuAccess.wdata;
            ext_q.dataOe  <= cpuAccess.write;
          end else if (cpuAccess.req && !goExt) begin
            done_q <= 1'b1;
          end
        end
        bmmd_pkg::BMMD_SETUP: begin
          state_q   <= bmmd_pkg::BMMD_STROBE;
          ext_q.rdN <= cpuAccess.write;
          ext_q.wrN <= !cpuAccess.write;
        end
        bmmd_pkg::BMMD_STROBE: begin
          state_q <= bmmd_pkg::BMMD_IDLE;
          done_q  <= 1'b1;
          ext_q   <= '{ceN: bmmd_pkg::CE_IDLE, rdN: 1'b1, wrN: 1'b1, dataOut: 8'h00, dataOe: 1'b0};
        end
        default: begin
          state_q <= bmmd_pkg::BMMD_IDLE;
        end
      endcase
    end
  end

  // Read data taken as the read strobe ends
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (state_q == bmmd_pkg::BMMD_STROBE && !cpuAccess.write) begin
      rdata_q <= ext_data_bus_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Single-chip and port release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      singleChip_q <= 1'b0;
    end else begin
      singleChip_q <= singleChipReq && modeInt_q && latched_q;
    end
  end

  // Internal service flag, one cycle behind the access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      intSel_q <= 1'b0;
    end else begin
      intSel_q <= cpuAccess.req && goInt;
    end
  end

  logic [7:0] portOut_q;
  logic [7:0] portOe_q;

  // One registered pin pair per port bit
  for (genvar p = 0; p < 8; p++) begin : gPort
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        portOut_q[p] <= bmmd_pkg::PORT_RESET[p];
        portOe_q[p]  <= bmmd_pkg::PORT_RESET[p];
      end else if (singleChip_q) begin
        portOut_q[p] <= portOut[p];
        portOe_q[p]  <= portOe[p];
      end else begin
        portOut_q[p] <= bmmd_pkg::PORT_RESET[p];
        portOe_q[p]  <= bmmd_pkg::PORT_RESET[p];
      end
    end
  end

  // Held at its fixed value, never set by the core
  logic flag_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= bmmd_pkg::CUSTOM_FLAG;
    end else begin
      flag_q <= bmmd_pkg::CUSTOM_FLAG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive, every output straight from a flop

  assign extBus                = ext_q;
  assign portPinOut            = portOut_q;
  assign portPinOe             = portOe_q;
  assign external_rom_mode     = extMode_q;
  assign singleChip            = singleChip_q;
  assign intSelect             = intSel_q;
  assign accessDone            = done_q;
  assign extRdata              = rdata_q;
  assign custom_condition_flag = flag_q;

endmodule

// *** verification/bmmd_ext_mem.sv ***
// Byte memory standing on the expansion bus
`timescale 1ns/100ps
module bmmd_ext_mem (
  input  wire logic                   ref_clk,
  input  wire bmmd_pkg::bmmd_ext_type bus,
  output logic [7:0]                  dataIn
);
  logic [7:0] mem_q = 8'h5a;
  always_ff @(posedge ref_clk) begin
    if (bus.ceN != 4'hf && !bus.wrN) mem_q <= bus.dataOut;
  end
  // Pull-up level when not read
  assign dataIn = (bus.ceN != 4'hf && !bus.rdN) ? mem_q : 8'hff;
endmodule

// *** verification/bmmd_decoder_asserts.sv ***
// Checker for the boot mode memory decoder
`timescale 1ns/100ps
module bmmd_asserts (
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire bmmd_pkg::bmmd_access_type cpuAccess,
  input wire logic                      busConfigured,
  input wire bmmd_pkg::bmmd_ext_type    extBus,
  input wire logic                      external_rom_mode,
  input wire logic                      singleChip,
  input wire logic                      accessDone,
  input wire logic                      custom_condition_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [22:0] a;
  logic        hit;
  logic [3:0]  age_q;
  assign a = cpuAccess.addr;
  // Expected external decode
  assign hit = busConfigured && !singleChip && (external_rom_mode ?
    (a <= 23'h3fffff && !(a >= 23'h00c000 && a <= 23'h00ffff)) : (a >= 23'h100000 && a <= 23'h4fffff));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  sequence go_s; $rose(cpuAccess.req) && hit; endsequence
  sequence ce_s; extBus.ceN != 4'hf && extBus.rdN && extBus.wrN; endsequence
  sequence rd_s; extBus.ceN != 4'hf && !extBus.rdN; endsequence
  sequence wr_s; !extBus.wrN && extBus.dataOe && extBus.dataOut == cpuAccess.wdata; endsequence
  sequence end_s; extBus.ceN == 4'hf && extBus.rdN && extBus.wrN && accessDone; endsequence
  a_ext_read: assert property (go_s ##0 !cpuAccess.write |=> ce_s ##1 rd_s ##1 end_s)
    else $error("external read walk wrong");
  a_ext_write: assert property (go_s ##0 cpuAccess.write |=> ce_s ##1 wr_s ##1 end_s)
    else $error("external write walk wrong");
  a_chip_index: assert property (go_s |=> extBus.ceN == ~(4'h1 << a[21:20]))
    else $error("wrong chip enable");
  a_no_strobe: assert property ($rose(cpuAccess.req) && !hit |=>
    (extBus.ceN == 4'hf && extBus.rdN && extBus.wrN)[*2]) else $error("strobe on internal access");
  a_quick_done: assert property ($rose(cpuAccess.req) && !hit |=> accessDone)
    else $error("internal access late");
  a_flag_zero: assert property (custom_condition_flag == 1'b0)
    else $error("condition flag set");
  a_single_internal: assert property (external_rom_mode |-> !singleChip)
    else $error("single chip in external mode");
  a_mode_held: assert property (age_q == 4'hf |-> $stable(external_rom_mode))
    else $error("mode changed without reset");
endmodule
bind bmmd_decoder bmmd_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cpuAccess(cpuAccess),
  .busConfigured(busConfigured), .extBus(extBus), .external_rom_mode(external_rom_mode),
  .singleChip(singleChip), .accessDone(accessDone), .custom_condition_flag(custom_condition_flag));

// *** verification/bmmd_decoder_test.sv ***
// Self-checking bench for the boot mode memory decoder
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module bmmd_decoder_test;
  logic                      ref_clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      strap = 1'b1;
  logic                      busCfg = 1'b0;
  logic                      scReq = 1'b0;
  bmmd_pkg::bmmd_access_type acc = '0;
  bmmd_pkg::bmmd_ext_type    extBus;
  logic [7:0]                extIn, pinOut, pinOe, rdata;
  logic                      extMode, sc, done, flag, seen, isel;
  int                        error_cnt = 0;
  int                        checked = 0;
  // Row is {mode, external expected, address}
  logic [24:0] rows [12] = '{25'h0000000, 25'h000c000, 25'h000ff00, 25'h0900000, 25'h0cfffff,
    25'h0500000, 25'h1800000, 25'h180bfff, 25'h1810000, 25'h100c000, 25'h100ff00, 25'h1bfffff};
  always #20 ref_clk = ~ref_clk;
  bmmd_decoder u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .boot_mode_strap(strap), .cpuAccess(acc),
    .busConfigured(busCfg), .singleChipReq(scReq), .portOut(8'h3c), .portOe(8'hc3),
    .ext_data_bus_in(extIn), .extBus(extBus), .portPinOut(pinOut), .portPinOe(pinOe),
    .external_rom_mode(extMode), .singleChip(sc), .intSelect(isel), .accessDone(done),
    .extRdata(rdata), .custom_condition_flag(flag));
  bmmd_ext_mem u_mem (.ref_clk(ref_clk), .bus(extBus), .dataIn(extIn));
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic boot(input logic s);
    rst_n = 1'b0;
    strap = s;
    busCfg = 1'b0;
    scReq = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    #400;
  endtask
  task automatic go(input logic w, input logic [22:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1 acc = '{1'b1, w, a, d};
    seen = 1'b0;
    for (int n = 0; n < 10 && !done; n++) begin
      @(posedge ref_clk) #1 seen |= extBus.ceN != 4'hf;
    end
    acc.req = 1'b0;
    `CHK(done, 1'b1)
  endtask
  task automatic sweep(input logic m);
    for (int i = 0; i < 12; i++) begin
      if (rows[i][24] == m) begin
        go(1'b0, rows[i][22:0], 8'h00);
        `CHK(seen, rows[i][23])
        `CHK(isel, !rows[i][23] && rows[i][22:0] <= bmmd_pkg::FONT_HI)
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    boot(1'b1);
    `CHK(extMode, 1'b0)
    `CHK(flag, 1'b0)
    go(1'b0, 23'h100000, 8'h00);
    `CHK(seen, 1'b0)
    busCfg = 1'b1;
    sweep(1'b0);
    go(1'b1, 23'h200000, 8'ha5);
    go(1'b0, 23'h200000, 8'h00);
    `CHK(rdata, 8'ha5)
    scReq = 1'b1;
    #120;
    `CHK(sc, 1'b1)
    `CHK({pinOut, pinOe}, 16'h3cc3)
    go(1'b0, 23'h100000, 8'h00);
    `CHK(seen, 1'b0)
    strap = 1'b0;
    #200;
    `CHK(extMode, 1'b0)
    boot(1'b0);
    `CHK(extMode, 1'b1)
    scReq = 1'b1;
    busCfg = 1'b1;
    #120;
    `CHK(sc, 1'b0)
    sweep(1'b1);
    go(1'b1, 23'h000010, 8'h3e);
    go(1'b0, 23'h000010, 8'h00);
    `CHK(rdata, 8'h3e)
    conclude();
  end
  initial begin
    #40000;
    error_cnt++;
    conclude();
  end
endmodule
